// ===== logic/mcg_clock_control.sv
// clock generation control: reference mux, dividers, squaring, phase tracking, apb registers
//
// Behaviour
// - reference select picks divided clock, recovered vc clock, secondary pin or external input.
// - divider source bit feeds the divider from master clock (0) or double-rate clock (1).
// - external squaring bit routes the squared external input to both multiplexers.
// - external squaring passes input rise as an unjittered falling edge, other edge at half period.
// - secondary squaring bit converts the secondary pin signal before the reference mux.
// - secondary squaring passes input rise as an unjittered rising edge, fall at half period.
// - generator source bit feeds the generator from master clock (0) or pll clock (1).
// - generator divide field, reset 11, divides by 8, 1, 2 or 4 to form the local clock.
// - phase lock enable with frame-sync type 00 slaves the frame generator to external sync.
// - standby master tracks external sync on the local clock so takeover starts in phase.
// - clock failure input stops phase tracking regardless of phase lock enable.
// - secondary drive bit makes the secondary pin an output, else an input.
// - secondary source bit drives external input path (0) or internal frame reference (1).
// - the programmable divider divides by divider value plus two.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
module mcg_clock_control #(
  parameter int FRAME_TICKS = 2048,
  parameter int DIV_W = 14
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [17:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // clock sources; double-rate and pll clocks sampled as enables in the master clock domain
  input wire logic double_rate_clock_in_i,
  input wire logic pll_clock_input_i,
  input wire logic recovered_vc_clock_i,
  input wire logic external_eight_k_input_i,
  input wire logic [1:0] tdm_frame_sync_type_i,
  input wire logic frame_sync_i,
  input wire logic clock_failure_input_i,
  // secondary pin as three signals
  input wire logic secondary_eight_k_pin_i,
  output logic secondary_eight_k_pin_o,
  output logic secondary_eight_k_pin_oe_o,
  // results
  output logic eight_k_reference_clock_o,
  output logic local_16m_clock_o,
  output logic internal_frame_reference_o,
  output logic tracking_active_o
);
  mcg_pkg::mcg_ctrl_t ctrl;
  mcg_pkg::mcg_ctrl_t next_ctrl;
  logic [DIV_W-1:0] div_value;
  logic [DIV_W-1:0] next_div_value;
  logic [31:0] next_prdata;
  logic wr_acc;
  logic rd_acc;
  logic hit;

  // apb decode: zero wait states, error on unmapped address
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && !penable_i && !pwrite_i;
  assign hit = paddr_i == mcg_pkg::CTRL_ADDR || paddr_i == mcg_pkg::DIV_ADDR
    || paddr_i == mcg_pkg::STAT_ADDR;
  // pready tied high: every access completes in its first access cycle
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;

  // register writes
  always_comb begin
    next_ctrl = ctrl;
    next_div_value = div_value;
    if (wr_acc && paddr_i == mcg_pkg::CTRL_ADDR) begin
      next_ctrl = pwdata_i[10:0];
    end
    if (wr_acc && paddr_i == mcg_pkg::DIV_ADDR) begin
      next_div_value = pwdata_i[DIV_W-1:0];
    end
  end

  // read data registered in setup phase
  always_comb begin
    next_prdata = prdata_o;
    if (rd_acc) begin
      unique case (paddr_i)
        mcg_pkg::CTRL_ADDR: next_prdata = {21'h00_0000, ctrl};
        mcg_pkg::DIV_ADDR: next_prdata = {{(32-DIV_W){1'b0}}, div_value};
        mcg_pkg::STAT_ADDR: next_prdata = {28'h000_0000, tracking_active_o,
          local_16m_clock_o, internal_frame_reference_o, eight_k_reference_clock_o};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl <= mcg_pkg::CTRL_RESET[10:0];
      div_value <= mcg_pkg::DIV_RESET[DIV_W-1:0];
      prdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ctrl <= next_ctrl;
      div_value <= next_div_value;
      prdata_o <= next_prdata;
    end
  end

  // source edges detected in master clock domain
  logic dr_prev;
  logic pll_prev;
  logic dr_tick;
  logic pll_tick;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      dr_prev <= 1'b0;
      pll_prev <= 1'b0;
    end else if (ce_i) begin
      dr_prev <= double_rate_clock_in_i;
      pll_prev <= pll_clock_input_i;
    end
  end
  assign dr_tick = double_rate_clock_in_i & ~dr_prev;
  assign pll_tick = pll_clock_input_i & ~pll_prev;

  // programmable 8 kHz divider: one reference period per value+2 source ticks,
  // high for the first half of the count; the source is the master clock or
  // the rising edges of the double-rate clock
  logic div_src_tick;
  logic div_out;
  logic div_pulse;
  logic [DIV_W-1:0] div_limit;
  assign div_src_tick = ctrl.div_src ? dr_tick : 1'b1;
  assign div_limit = div_value + {{(DIV_W-1){1'b0}}, 1'b1};
  mcg_divider #(.W(DIV_W)) u_refdiv (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .tick_i(div_src_tick),
    .limit_i(div_limit),
    .out_o(div_out),
    .pulse_o(div_pulse)
  );

  // squaring of the external and secondary inputs
  logic ext_sq;
  logic sec_sq;
  logic ext_path;
  logic sec_path;
  mcg_squarer #(.INVERT(1'b1)) u_ext_sq (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .sig_i(external_eight_k_input_i),
    .sq_o(ext_sq)
  );
  mcg_squarer #(.INVERT(1'b0)) u_sec_sq (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .sig_i(secondary_eight_k_pin_i),
    .sq_o(sec_sq)
  );
  assign ext_path = ctrl.ext_sq ? ext_sq : external_eight_k_input_i;
  assign sec_path = ctrl.sec_sq ? sec_sq : secondary_eight_k_pin_i;

  // reference multiplexer
  always_comb begin
    unique case (ctrl.ref_sel)
      mcg_pkg::REF_DIVIDED: eight_k_reference_clock_o = div_out;
      mcg_pkg::REF_RECOVERED: eight_k_reference_clock_o = recovered_vc_clock_i;
      mcg_pkg::REF_SECONDARY: eight_k_reference_clock_o = sec_path;
      mcg_pkg::REF_EXTERNAL: eight_k_reference_clock_o = ext_path;
    endcase
  end

  // secondary pin drive and source
  assign secondary_eight_k_pin_oe_o = ctrl.sec_drive;
  assign secondary_eight_k_pin_o = ctrl.sec_sel ? internal_frame_reference_o : ext_path;

  // tdm generator: selected source divided by 8, 1, 2 or 4
  logic gen_tick;
  logic [2:0] gen_cnt;
  logic [2:0] next_gen_cnt;
  logic [2:0] gen_limit;
  logic local_16m_clock_tick;
  logic next_local_16m_clock;
  assign gen_tick = ctrl.gen_src ? pll_tick : 1'b1;
  always_comb begin
    unique case (ctrl.gen_div)
      mcg_pkg::GDIV_8: gen_limit = 3'h7;
      mcg_pkg::GDIV_1: gen_limit = 3'h0;
      mcg_pkg::GDIV_2: gen_limit = 3'h1;
      mcg_pkg::GDIV_4: gen_limit = 3'h3;
    endcase
  end
  assign local_16m_clock_tick = gen_tick && gen_cnt >= gen_limit;
  always_comb begin
    next_gen_cnt = gen_cnt;
    next_local_16m_clock = local_16m_clock_o;
    if (gen_tick) begin
      next_gen_cnt = local_16m_clock_tick ? 3'h0 : gen_cnt + 3'h1;
      next_local_16m_clock = local_16m_clock_tick ? ~local_16m_clock_o : local_16m_clock_o;
    end
  end

  // frame reference generator, slaved to external sync while tracking
  logic [11:0] frame_cnt;
  logic [11:0] next_frame_cnt;
  logic fs_prev;
  logic fs_rise;
  localparam logic [11:0] FRAME_LAST = 12'(FRAME_TICKS - 1);
  assign fs_rise = frame_sync_i & ~fs_prev;
  assign tracking_active_o = ctrl.phase_lock && !clock_failure_input_i
    && tdm_frame_sync_type_i == mcg_pkg::FS_TYPE_TRACK;
  always_comb begin
    next_frame_cnt = frame_cnt;
    if (tracking_active_o && fs_rise) begin
      next_frame_cnt = 12'h000;
    end else if (local_16m_clock_tick) begin
      next_frame_cnt = (frame_cnt == FRAME_LAST) ? 12'h000 : frame_cnt + 12'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      gen_cnt <= 3'h0;
      local_16m_clock_o <= 1'b0;
      frame_cnt <= 12'h000;
      fs_prev <= 1'b0;
      internal_frame_reference_o <= 1'b0;
    end else if (ce_i) begin
      gen_cnt <= next_gen_cnt;
      local_16m_clock_o <= next_local_16m_clock;
      frame_cnt <= next_frame_cnt;
      fs_prev <= frame_sync_i;
      internal_frame_reference_o <= next_frame_cnt < 12'(FRAME_TICKS / 2);
    end
  end

  // tracking gate and frame alignment
  chk_fail_stops: assert property (@(posedge clk_i) disable iff (!nrst_i)
    clock_failure_input_i |-> !tracking_active_o)
    else $error("tracking active during clock failure");
  chk_phase_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !ctrl.phase_lock |-> !tracking_active_o)
    else $error("tracking active without phase lock enable");
  chk_track_align: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && tracking_active_o && fs_rise |=> frame_cnt == 12'h000)
    else $error("frame counter not aligned to external sync");

  // reference multiplexer and divider source
  chk_ref_div: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ctrl.ref_sel == mcg_pkg::REF_DIVIDED |-> eight_k_reference_clock_o == div_out)
    else $error("reference mux wrong for divided clock");
  chk_ref_ext: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ctrl.ref_sel == mcg_pkg::REF_EXTERNAL && !ctrl.ext_sq
    |-> eight_k_reference_clock_o == external_eight_k_input_i)
    else $error("reference mux wrong for external input");
  chk_ref_sec_raw: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ctrl.ref_sel == mcg_pkg::REF_SECONDARY && !ctrl.sec_sq |-> eight_k_reference_clock_o == secondary_eight_k_pin_i)
    else $error("unsquared secondary input altered");
  chk_div_src: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && ctrl.div_src && !dr_tick && $stable(div_limit) |=> $stable(div_out))
    else $error("divider advanced without double-rate edge");

  // secondary pin direction and source
  chk_sec_drive: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && wr_acc && paddr_i == mcg_pkg::CTRL_ADDR
    |=> secondary_eight_k_pin_oe_o == $past(pwdata_i[mcg_pkg::SECDRV_BIT]))
    else $error("secondary pin enable mismatch");
  chk_sec_src: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ctrl.sec_sel |-> secondary_eight_k_pin_o == internal_frame_reference_o)
    else $error("secondary pin source wrong");
  chk_sq_route: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ctrl.ext_sq && !ctrl.sec_sel |-> secondary_eight_k_pin_o == ext_sq)
    else $error("squared external not routed to secondary");

  // generator divide and source
  chk_gen_div1: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && ctrl.gen_div == mcg_pkg::GDIV_1 && !ctrl.gen_src && $stable(ctrl)
    |=> local_16m_clock_o != $past(local_16m_clock_o))
    else $error("divide-by-one generator not toggling");
  chk_gen_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && ctrl.gen_src && !pll_tick |=> $stable(local_16m_clock_o))
    else $error("generator advanced without pll edge");

  // register writes land, unmapped writes are dropped
  chk_ctrl_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && wr_acc && paddr_i == mcg_pkg::CTRL_ADDR |=> ctrl == $past(pwdata_i[10:0]))
    else $error("control write did not land");
  chk_unmapped_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && wr_acc && !hit |=> $stable(ctrl) && $stable(div_value))
    else $error("unmapped write changed a register");

  // main scenarios
  cov_track: cover property (@(posedge clk_i) tracking_active_o && fs_rise);
  cov_fail: cover property (@(posedge clk_i) tracking_active_o ##1 clock_failure_input_i);
  cov_pll: cover property (@(posedge clk_i) ctrl.gen_src && local_16m_clock_tick);
  cov_div_wrap: cover property (@(posedge clk_i) disable iff (!nrst_i) div_pulse);
endmodule

// ===== common/mcg_pkg.sv
// package: register map, field positions and timing constants of the clock generation control
package mcg_pkg;
  // register indices; each register takes one aligned word at four times its index
  localparam logic [15:0] CTRL_IDX = 16'h6090;
  localparam logic [15:0] DIV_IDX = 16'h6092;
  localparam logic [15:0] STAT_IDX = 16'h6094;
  // register byte addresses
  localparam logic [17:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [17:0] DIV_ADDR = {DIV_IDX, 2'b00};
  localparam logic [17:0] STAT_ADDR = {STAT_IDX, 2'b00};
  // control field positions
  localparam int REFERENCE_SOURCE_SELECT_LSB = 0;
  localparam int DIVSRC_BIT = 2;
  localparam int EXSQ_BIT = 3;
  localparam int SECSQ_BIT = 4;
  localparam int GENSRC_BIT = 5;
  localparam int GDIV_LSB = 6;
  localparam int PHLOCK_BIT = 8;
  localparam int SECDRV_BIT = 9;
  localparam int SECSEL_BIT = 10;
  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h00c0;
  localparam logic [13:0] DIV_RESET = 14'h2000;
  localparam logic [10:0] CTRL_MASK = 11'h7ff;
  // reference select codes
  localparam logic [1:0] REF_DIVIDED = 2'b00;
  localparam logic [1:0] REF_RECOVERED = 2'b01;
  localparam logic [1:0] REF_SECONDARY = 2'b10;
  localparam logic [1:0] REF_EXTERNAL = 2'b11;
  // generator divide codes
  localparam logic [1:0] GDIV_8 = 2'b00;
  localparam logic [1:0] GDIV_1 = 2'b01;
  localparam logic [1:0] GDIV_2 = 2'b10;
  localparam logic [1:0] GDIV_4 = 2'b11;
  localparam logic [1:0] FS_TYPE_TRACK = 2'b00;
  // squaring counter width: up to 32767 clocks per period
  localparam int SQ_CNT_W = 15;
  localparam logic [13:0] DIV_OFFSET = 14'h0002;
  // control register as fields
  typedef struct packed {
    logic sec_sel;
    logic sec_drive;
    logic phase_lock;
    logic [1:0] gen_div;
    logic gen_src;
    logic sec_sq;
    logic ext_sq;
    logic div_src;
    logic [1:0] ref_sel;
  } mcg_ctrl_t;
endpackage

// ===== logic/mcg_squarer.sv
// squaring of an 8 kHz pulse input into a near square wave
`timescale 1ns/1ps
module mcg_squarer #(
  parameter int CW = mcg_pkg::SQ_CNT_W,
  parameter bit INVERT = 1'b0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic sig_i,
  output logic sq_o
);
  logic prev;
  logic level;
  logic [CW-1:0] cnt;
  logic [CW-1:0] period;
  logic next_prev;
  logic next_level;
  logic [CW-1:0] next_cnt;
  logic [CW-1:0] next_period;
  logic rise;

  assign rise = sig_i & ~prev;
  // measure period, raise level on input rise, drop at half period
  always_comb begin
    next_prev = sig_i;
    next_level = level;
    next_cnt = cnt;
    next_period = period;
    if (rise) begin
      next_period = cnt;
      next_cnt = '0;
      next_level = 1'b1;
    end else begin
      if (cnt != {CW{1'b1}}) begin
        next_cnt = cnt + 1'b1;
      end
      if (cnt == (period >> 1)) begin
        next_level = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      prev <= 1'b0;
      level <= 1'b0;
      cnt <= '0;
      period <= '0;
    end else if (ce_i) begin
      prev <= next_prev;
      level <= next_level;
      cnt <= next_cnt;
      period <= next_period;
    end
  end

  // rise edge passed combinationally, no added jitter; inverted when INVERT is set
  assign sq_o = INVERT ? ~(rise | level) : (rise | level);

  chk_half_drop: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && !rise && level && cnt == (period >> 1) |=> !level)
    else $error("squared level not dropped at half period");
  chk_rise_pass: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rise |-> sq_o == !INVERT)
    else $error("input rise not passed at once");
  cov_rise: cover property (@(posedge clk_i) disable iff (!nrst_i) rise ##[2:100] rise);
endmodule

// ===== logic/mcg_divider.sv
// programmable clock-enable divider: terminal pulse every limit+1 source ticks
`timescale 1ns/1ps
module mcg_divider #(
  parameter int W = 14
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic [W-1:0] limit_i,
  output logic out_o,
  output logic pulse_o
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_out;
  logic [W-1:0] half;

  assign half = limit_i >> 1;
  assign pulse_o = tick_i && (cnt >= limit_i);
  // count source ticks 0..limit, output high for the first half of each turn
  always_comb begin
    next_cnt = cnt;
    if (tick_i) begin
      if (cnt >= limit_i) begin
        next_cnt = '0;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
    next_out = next_cnt <= half;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt <= '0;
      out_o <= 1'b0;
    end else if (ce_i) begin
      cnt <= next_cnt;
      out_o <= next_out;
    end
  end

  chk_wrap_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && pulse_o |=> cnt == '0)
    else $error("divider did not wrap");
endmodule

// ===== test/mcg_far_side.sv
// far side model: external 8 kHz pulse sources, frame sync and slow clock levels
`timescale 1ns/1ps
module mcg_far_side #(
  parameter int PER = 48
) (
  input wire logic clk_i,
  output logic ext_o,
  output logic sec_o,
  output logic frame_sync_o,
  output logic pll_o,
  output logic dbl_o
);
  int cnt = 0;
  // short pulses once per period; pll ticks every 6 cycles, double-rate every 4
  always @(posedge clk_i) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    ext_o <= (cnt < 4);
    sec_o <= (cnt < 4);
    frame_sync_o <= (cnt == 0);
    pll_o <= ((cnt % 6) < 3);
    dbl_o <= ((cnt % 4) < 2);
  end
endmodule

// ===== test/mcg_clock_control_test.sv
// testbench: register access, reference selection, dividers, squaring and tracking
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mcg_clock_control_test;
  logic clk_i, nrst_i, psel, penable, pwrite, vc, fail, ext, sec, fs, pll, dbl;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, perr, err, pin_o, pin_oe, pin, ref8, local_16m_clock, fref, trk;
  logic [1:0] fs_type;
  mcg_pkg::mcg_ctrl_t c;
  int num_errors = 0;
  int n_checks = 0;
  int p, p1;
  int dv[4] = '{8, 1, 2, 4};
  // secondary pin level: device when enabled, else the far side
  assign pin = pin_oe ? pin_o : sec;
  mcg_far_side #(.PER(48)) far (.clk_i(clk_i), .ext_o(ext), .sec_o(sec), .frame_sync_o(fs),
    .pll_o(pll), .dbl_o(dbl));
  mcg_clock_control #(.FRAME_TICKS(16)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .double_rate_clock_in_i(dbl), .pll_clock_input_i(pll), .recovered_vc_clock_i(vc),
    .external_eight_k_input_i(ext), .tdm_frame_sync_type_i(fs_type), .frame_sync_i(fs),
    .clock_failure_input_i(fail), .secondary_eight_k_pin_i(pin),
    .secondary_eight_k_pin_o(pin_o), .secondary_eight_k_pin_oe_o(pin_oe),
    .eight_k_reference_clock_o(ref8), .local_16m_clock_o(local_16m_clock),
    .internal_frame_reference_o(fref), .tracking_active_o(trk));
  // master clock
  initial begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  task print_verdict;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = perr;
    if (n >= 20) begin
      num_errors++;
      print_verdict;
    end
    psel <= 0; penable <= 0;
  endtask
  task wr_ctl;
    apb(1, mcg_pkg::CTRL_ADDR, {21'h0, c});
  endtask
  // cycles between two rising edges of the reference (0) or local clock (1)
  task period(input bit which, output int q);
    int n, k;
    logic a, b;
    k = 0; q = 0; a = which ? local_16m_clock : ref8;
    for (n = 0; n < 4000 && k < 3; n++) begin
      @(negedge clk_i);
      b = which ? local_16m_clock : ref8;
      if (b && !a) k++;
      if (k == 2) q++;
      a = b;
    end
    if (k < 3) begin
      num_errors++;
      print_verdict;
    end
  endtask
  // squared output sampled 10 and 34 cycles after an input rise
  task sq_check(input logic inv);
    int n;
    repeat (150) @(posedge clk_i);
    for (n = 0; n < 200 && ext !== 1'b0; n++) @(posedge clk_i);
    for (n = 0; n < 200 && ext !== 1'b1; n++) @(posedge clk_i);
    if (n >= 200) begin
      num_errors++;
      print_verdict;
    end
    repeat (9) @(posedge clk_i);
    @(negedge clk_i);
    `CHK(ref8, ~inv)
    if (inv) `CHK(pin_o, 1'b0)
    repeat (24) @(posedge clk_i);
    @(negedge clk_i);
    `CHK(ref8, inv)
    if (inv) `CHK(pin_o, 1'b1)
  endtask
  // main sequence
  initial begin
    nrst_i = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    vc = 0; fail = 0; fs_type = 2'b01;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1;
    apb(0, mcg_pkg::CTRL_ADDR, 0);
    `CHK(rd, {16'h0, mcg_pkg::CTRL_RESET})
    apb(0, mcg_pkg::DIV_ADDR, 0);
    `CHK(rd, {18'h0, mcg_pkg::DIV_RESET})
    apb(0, 18'h0_00f0, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1, mcg_pkg::CTRL_ADDR, 32'hffff_ffff);
    apb(0, mcg_pkg::CTRL_ADDR, 0);
    `CHK(rd, {21'h0, mcg_pkg::CTRL_MASK})
    c = '0;
    c.ref_sel = mcg_pkg::REF_RECOVERED;
    wr_ctl;
    vc <= 1;
    @(negedge clk_i);
    `CHK(ref8, 1'b1)
    @(posedge clk_i);
    vc <= 0;
    @(negedge clk_i);
    `CHK(ref8, 1'b0)
    for (int i = 0; i < 2; i++) begin
      c.ref_sel = i ? mcg_pkg::REF_EXTERNAL : mcg_pkg::REF_SECONDARY;
      c.sec_drive = (i == 1);
      wr_ctl;
      repeat (48) begin
        @(negedge clk_i);
        `CHK(ref8, i ? ext : pin)
        `CHK(pin_oe, c.sec_drive)
        if (i) `CHK(pin_o, ext)
      end
    end
    c.sec_sel = 1;
    wr_ctl;
    repeat (48) begin
      @(negedge clk_i);
      `CHK(pin_o, fref)
    end
    c = '0;
    c.ref_sel = mcg_pkg::REF_EXTERNAL;
    c.ext_sq = 1;
    c.sec_drive = 1;
    wr_ctl;
    sq_check(1);
    c = '0;
    c.ref_sel = mcg_pkg::REF_SECONDARY;
    c.sec_sq = 1;
    wr_ctl;
    sq_check(0);
    c = '0;
    wr_ctl;
    apb(1, mcg_pkg::DIV_ADDR, 32'h0000_0003);
    period(0, p);
    `CHK(p, 3 + 2)
    c.div_src = 1;
    wr_ctl;
    period(0, p);
    `CHK(p, 4 * (3 + 2))
    c.gen_div = mcg_pkg::GDIV_1;
    wr_ctl;
    period(1, p1);
    `CHK(p1, 2)
    for (int g = 0; g < 4; g++) begin
      c.gen_div = g[1:0];
      c.gen_src = 0;
      wr_ctl;
      period(1, p);
      `CHK(p, dv[g] * p1)
      c.gen_src = 1;
      wr_ctl;
      period(1, p);
      `CHK(p, 6 * dv[g] * p1)
    end
    c = '0;
    c.phase_lock = 1;
    wr_ctl;
    fs_type <= mcg_pkg::FS_TYPE_TRACK;
    @(negedge clk_i);
    `CHK(trk, 1'b1)
    apb(0, mcg_pkg::STAT_ADDR, 0);
    `CHK(rd[3], 1'b1)
    // while tracking, each sync pulse restarts the frame before its first half ends
    for (p = 0; p < 100 && fs !== 1'b1; p++) @(negedge clk_i);
    `CHK(fs, 1'b1)
    repeat (150) begin
      @(negedge clk_i);
      `CHK(fref, 1'b1)
    end
    @(posedge clk_i);
    fail <= 1;
    @(negedge clk_i);
    `CHK(trk, 1'b0)
    @(posedge clk_i);
    fail <= 0;
    fs_type <= 2'b01;
    @(negedge clk_i);
    `CHK(trk, 1'b0)
    print_verdict;
  end
endmodule
